// *** hw/smc_clk_gate.sv ***
// Glitch-free clock gate enable: enable changes only while clock is low.
`timescale 1ns/1ps
module smc_clk_gate (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_run,
  output logic o_gate_en
);
  // Latch-free form: a negedge flop keeps the enable stable in the high phase.
  always_ff @(negedge i_sys_clk) begin
    if (!i_rstn) begin
      o_gate_en <= 1'b1;
    end else begin
      o_gate_en <= i_run;
    end
  end
endmodule

// *** hw/smc_sleep_ctrl.sv ***
// Sleep-mode controller: state entry, clock-domain gating and wake-up.
`timescale 1ns/1ps
`include "smc_cfg.svh"
// Functional notes
// - Sleep entered only when enable bit set and sleep instruction executes.
// - Interrupt wake holds core four cycles plus start-up, then resumes.
// - Register file and SRAM are never cleared across sleep.
// - Reset during sleep wakes core and restarts from reset vector.
// - Select 000 is Idle: only CPU and flash clocks stop.
// - Idle or ADC noise reduction with ADC on starts a conversion.
// - Select 001 stops I/O, CPU, flash clocks; ADC and async run.
// - ADC noise reduction wakes only from its listed sources.
// - Select 010 Power-down stops oscillator and all generated clocks.
// - Power-down wakes on resets, serial start, level zero, pin change.
// - Power-down wake waits a start-up time set by clock-source fuses.
// - Select 011 Power-save is Power-down plus timer2 and display.
// - Power-save timer2 wake needs its mask bit and global enable.
// - Power-save stops async oscillator if no user of async clock.
// - Power-save stops main clock if no synchronous user; else only them.
// - Select 110 with crystal is Standby; oscillator runs, six-cycle wake.
// - Encodings 100, 101 and 111 are reserved.
module smc_sleep_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_sleep_instr,
  input wire logic i_sleep_enable_bit,
  input wire logic [2:0] i_sleep_state_select,
  input wire logic i_crystal_selected,
  input wire logic [15:0] i_clock_source_fuses_wait,
  input wire logic i_reset_req,
  input wire logic i_global_irq_en,
  input wire logic i_adc_enabled,
  input wire logic i_adc_done_irq,
  input wire logic i_spm_ee_ready_irq,
  input wire logic i_ext_zero_level_irq,
  input wire logic i_ext_zero_edge_irq,
  input wire logic i_pin_change_irq,
  input wire logic i_serial_start_irq,
  input wire logic i_display_irq,
  input wire logic i_display_async,
  input wire logic i_display_sync,
  input wire logic i_timer2_ovf,
  input wire logic i_timer2_cmp,
  input wire logic [1:0] i_timer2_irq_mask,
  input wire logic i_timer2_async,
  input wire logic i_timer2_sync,
  input wire logic i_other_io_irq,
  output logic o_cpu_clk_en,
  output logic o_flash_clk_en,
  output logic o_io_clk_en,
  output logic o_adc_clk_en,
  output logic o_async_clk_en,
  output logic o_t2_lcd_sync_clk_en,
  output logic o_main_osc_en,
  output logic o_timer_osc_en,
  output logic o_adc_start,
  output logic o_core_halt,
  output logic o_restart_vector,
  output logic o_sleeping,
  output logic [2:0] o_sleep_mode
);
  import smc_pkg::*;

  smc_state_type state;
  logic [2:0] mode;
  logic [15:0] wait_cnt;
  logic wake;
  logic run_cpu, run_io, run_adc, run_asy, run_t2s;
  logic t2_wake;
  // Gate requests and enables, ordered cpu, io, adc, async, t2/display sync.
  // Flash shares the CPU gate because the two always stop together.
  logic [4:0] run_vec;
  logic [4:0] gate_vec;
  // High while the core is active and a sleep instruction meets a set enable bit, whatever the select.
  logic sleep_take;

  // Standby needs a crystal that can keep running, so without one the
  // encoding is treated like a reserved one and simply ignored.
  function automatic logic sel_valid(input logic [2:0] sel,
                                     input logic xtal);
    sel_valid = (sel == `SMC_SEL_IDLE) || (sel == `SMC_SEL_ADCNR) ||
                (sel == `SMC_SEL_PDOWN) || (sel == `SMC_SEL_PSAVE) ||
                ((sel == `SMC_SEL_STBY) && xtal);
  endfunction

  // Deep modes are the ones whose generated clocks may all stop, so their wake-up must
  // wait for the clock source to settle.
  function automatic logic deep_mode(input logic [2:0] m);
    deep_mode = (m == `SMC_SEL_PDOWN) || (m == `SMC_SEL_PSAVE) ||
                (m == `SMC_SEL_STBY);
  endfunction

  // A sleep instruction only counts while the core runs and may sleep.
  assign sleep_take = state == SMC_ACTIVE && i_sleep_instr &&
                      i_sleep_enable_bit;

  // Timer2 events wake Power-save only when software would also take the
  // interrupt; otherwise the core would wake to find nothing to service.
  assign t2_wake = i_global_irq_en &&
    ((i_timer2_ovf && i_timer2_irq_mask[0]) ||
     (i_timer2_cmp && i_timer2_irq_mask[1]));

  // Edge interrupts on external input zero are never a deep-sleep source.
  // The edge detector needs the I/O clock, which is stopped in every mode
  // except Idle, so only the level form can be seen there.
  always_comb begin
    wake = 1'b0;
    unique case (mode)
      `SMC_SEL_IDLE: begin
        wake = i_adc_done_irq || i_spm_ee_ready_irq || i_ext_zero_level_irq ||
               i_ext_zero_edge_irq || i_pin_change_irq ||
               i_serial_start_irq || i_display_irq || i_timer2_ovf ||
               i_timer2_cmp || i_other_io_irq;
      end
      `SMC_SEL_ADCNR: begin
        wake = i_adc_done_irq || i_spm_ee_ready_irq ||
               i_ext_zero_level_irq || i_pin_change_irq ||
               i_serial_start_irq || i_display_irq ||
               i_timer2_ovf || i_timer2_cmp;
      end
      `SMC_SEL_PSAVE: begin
        wake = i_ext_zero_level_irq || i_pin_change_irq ||
               i_serial_start_irq || i_display_irq || t2_wake;
      end
      default: begin
        wake = i_ext_zero_level_irq || i_pin_change_irq ||
               i_serial_start_irq;
      end
    endcase
  end

  // Wake-up runs SLEEP, START for the clock settling time, then HALT for a
  // fixed four cycles before the core is released. A reset request in SLEEP or
  // START wins over a wake source, so the core restarts instead of resuming.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state <= SMC_ACTIVE;
      mode <= `SMC_SEL_IDLE;
      wait_cnt <= 16'h0000;
    end else begin
      unique case (state)
        SMC_ACTIVE: begin
          if (i_sleep_instr && i_sleep_enable_bit &&
              sel_valid(i_sleep_state_select, i_crystal_selected)) begin
            state <= SMC_SLEEP;
            mode <= i_sleep_state_select;
          end
        end
        SMC_SLEEP: begin
          if (i_reset_req) begin
            state <= SMC_RESET;
          end else if (wake) begin
            state <= SMC_START;
            if (mode == `SMC_SEL_STBY) begin
              wait_cnt <= 16'(`SMC_STBY_CYCLES);
            end else if (deep_mode(mode)) begin
              wait_cnt <= i_clock_source_fuses_wait;
            end else begin
              wait_cnt <= 16'h0000;
            end
          end
        end
        SMC_START: begin
          // A count of zero or one still spends one cycle here, which keeps
          // the halt length the same for every mode.
          if (i_reset_req) begin
            state <= SMC_RESET;
          end else if (wait_cnt <= 16'h0001) begin
            state <= SMC_HALT;
            wait_cnt <= 16'(`SMC_HALT_CYCLES);
          end else begin
            wait_cnt <= wait_cnt - 16'h0001;
          end
        end
        SMC_HALT: begin
          // A reset here is left to the core's own reset path, since the
          // clocks are already running again.
          if (wait_cnt <= 16'h0001) begin
            state <= SMC_ACTIVE;
          end else begin
            wait_cnt <= wait_cnt - 16'h0001;
          end
        end
        SMC_RESET: begin
          state <= SMC_ACTIVE;
        end
        default: begin
          state <= SMC_ACTIVE;
        end
      endcase
    end
  end

  // Domain run requests; memories are never touched, only clocks.
  // Stopping a clock freezes its domain, so state survives the sleep.
  // The requests are combinational and only become enables on a falling edge.
  always_comb begin
    run_cpu = 1'b1;
    run_io = 1'b1;
    run_adc = 1'b1;
    run_asy = 1'b1;
    run_t2s = 1'b1;
    if (state == SMC_SLEEP || state == SMC_START) begin
      run_cpu = 1'b0;
      unique case (mode)
        `SMC_SEL_IDLE: begin
          run_io = 1'b1;
        end
        `SMC_SEL_ADCNR: begin
          run_io = 1'b0;
          run_t2s = 1'b0;
        end
        `SMC_SEL_PSAVE: begin
          run_io = 1'b0;
          run_adc = 1'b0;
          run_asy = i_timer2_async || i_display_async;
          run_t2s = i_timer2_sync || i_display_sync;
        end
        default: begin
          run_io = 1'b0;
          run_adc = 1'b0;
          run_asy = 1'b0;
          run_t2s = 1'b0;
        end
      endcase
      // I/O and ADC clocks must be back before the start-up wait can complete.
      if (state == SMC_START && mode != `SMC_SEL_IDLE) begin
        run_io = 1'b1;
        run_adc = 1'b1;
      end
    end
  end

  // One glitch-free gate per domain, all built the same way.
  assign run_vec = {run_t2s, run_asy, run_adc, run_io, run_cpu};
  for (genvar g = 0; g < 5; g++) begin : g_gate
    smc_clk_gate u_gate (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .i_run(run_vec[g]),
      .o_gate_en(gate_vec[g])
    );
  end
  assign o_cpu_clk_en = gate_vec[0];
  assign o_flash_clk_en = gate_vec[0];
  assign o_io_clk_en = gate_vec[1];
  assign o_adc_clk_en = gate_vec[2];
  assign o_async_clk_en = gate_vec[3];
  assign o_t2_lcd_sync_clk_en = gate_vec[4];

  // Main oscillator: Power-down stops it outright, Power-save keeps it only
  // while a synchronously clocked timer2 or display still needs it.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_main_osc_en <= 1'b1;
    end else if (state == SMC_SLEEP) begin
      unique case (mode)
        `SMC_SEL_PDOWN: begin
          o_main_osc_en <= 1'b0;
        end
        `SMC_SEL_PSAVE: begin
          o_main_osc_en <= i_timer2_sync || i_display_sync;
        end
        `SMC_SEL_STBY: begin
          o_main_osc_en <= 1'b1;
        end
        default: begin
          o_main_osc_en <= 1'b1;
        end
      endcase
    end else begin
      o_main_osc_en <= 1'b1;
    end
  end

  // Timer oscillator: in sleep, kept only while an asynchronous user is left, so an
  // unused watch crystal draws no current in the deep modes.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_timer_osc_en <= 1'b1;
    end else if (state == SMC_SLEEP) begin
      unique case (mode)
        `SMC_SEL_PDOWN: begin
          o_timer_osc_en <= 1'b0;
        end
        `SMC_SEL_PSAVE: begin
          o_timer_osc_en <= i_timer2_async || i_display_async;
        end
        `SMC_SEL_STBY: begin
          o_timer_osc_en <= 1'b0;
        end
        default: begin
          o_timer_osc_en <= i_timer2_async || i_display_async;
        end
      endcase
    end else begin
      o_timer_osc_en <= 1'b1;
    end
  end

  // The conversion is started the cycle after the sleep is taken, so that it
  // runs in the quiet period while the core clock is stopped.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_adc_start <= 1'b0;
    end else begin
      o_adc_start <= i_adc_enabled && sleep_take &&
        (i_sleep_state_select == `SMC_SEL_IDLE ||
        i_sleep_state_select == `SMC_SEL_ADCNR);
    end
  end

  // The restart pulse tells the core to fetch from the reset vector rather
  // than from the instruction after the sleep.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_restart_vector <= 1'b0;
    end else begin
      o_restart_vector <= (state == SMC_SLEEP || state == SMC_START) &&
                          i_reset_req;
    end
  end

  // Halt covers every state but ACTIVE, so the core never sees a partial
  // wake-up sequence.
  assign o_core_halt = state != SMC_ACTIVE;
  assign o_sleeping = state == SMC_SLEEP;
  assign o_sleep_mode = mode;
endmodule

// *** inc/smc_cfg.svh ***
// Constants for the sleep-mode controller: encodings and timing counts.
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
`define SMC_SEL_IDLE 3'h0
`define SMC_SEL_ADCNR 3'h1
`define SMC_SEL_PDOWN 3'h2
`define SMC_SEL_PSAVE 3'h3
`define SMC_SEL_STBY 3'h6
`define SMC_HALT_CYCLES 4'h4
`define SMC_STBY_CYCLES 4'h6
`define SMC_WAIT_W 16
`endif

// *** inc/smc_pkg.sv ***
// Types shared by the sleep-mode controller files.
package smc_pkg;
  typedef enum logic [2:0] {
    SMC_ACTIVE = 3'b000,
    SMC_SLEEP = 3'b001,
    SMC_START = 3'b010,
    SMC_HALT = 3'b011,
    SMC_RESET = 3'b100
  } smc_state_type;
endpackage

// *** test/smc_sleep_ctrl_asserts.sv ***
// Concurrent checks on the ports of the sleep-mode controller.
`timescale 1ns/1ps
module smc_sleep_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_sleep_instr,
  input wire logic i_sleep_enable_bit,
  input wire logic [2:0] i_sleep_state_select,
  input wire logic i_adc_enabled,
  input wire logic i_reset_req,
  input wire logic i_timer2_async,
  input wire logic i_timer2_sync,
  input wire logic i_display_async,
  input wire logic i_display_sync,
  input wire logic o_cpu_clk_en,
  input wire logic o_flash_clk_en,
  input wire logic o_io_clk_en,
  input wire logic o_adc_clk_en,
  input wire logic o_async_clk_en,
  input wire logic o_main_osc_en,
  input wire logic o_timer_osc_en,
  input wire logic o_adc_start,
  input wire logic o_core_halt,
  input wire logic o_restart_vector,
  input wire logic o_sleeping,
  input wire logic [2:0] o_sleep_mode
);
  logic [4:0] gates;
  logic [2:0] sel;
  logic take, was, asleep;
  assign sel = i_sleep_state_select;
  assign gates = {o_cpu_clk_en, o_flash_clk_en, o_io_clk_en, o_adc_clk_en,
    o_async_clk_en};
  assign take = !o_core_halt && i_sleep_instr && i_sleep_enable_bit;
  // Gates move on the falling edge, so a mode is judged one cycle in.
  always_ff @(posedge i_sys_clk) begin
    was <= i_rstn && o_sleeping;
  end
  assign asleep = o_sleeping && was;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  property p_enter; take && sel < 3'h4 |=> o_sleeping; endproperty
  a_enter: assert property (p_enter) else $error("no entry");
  property p_mode; take && sel < 3'h4 |=> o_sleep_mode == $past(sel);
  endproperty
  a_mode: assert property (p_mode) else $error("mode lost");
  property p_refuse; !o_core_halt && i_sleep_instr && (!i_sleep_enable_bit
    || sel[2] && sel != 3'h6) |=> !o_core_halt; endproperty
  a_refuse: assert property (p_refuse) else $error("bad entry");
  property p_idle; asleep && o_sleep_mode == 3'h0 |-> gates == 5'h07;
  endproperty
  a_idle: assert property (p_idle) else $error("idle gates");
  property p_adcnr; asleep && o_sleep_mode == 3'h1 |-> gates == 5'h03;
  endproperty
  a_adcnr: assert property (p_adcnr) else $error("adcnr gates");
  property p_pdown; asleep && o_sleep_mode == 3'h2 |->
    gates == 5'h00 && !o_main_osc_en && !o_timer_osc_en; endproperty
  a_pdown: assert property (p_pdown) else $error("pdown clocks");
  property p_psave; asleep && o_sleep_mode == 3'h3 |->
    o_timer_osc_en == (i_timer2_async || i_display_async); endproperty
  a_psave: assert property (p_psave) else $error("psave osc");
  property p_psync; asleep && o_sleep_mode == 3'h3 |->
    o_main_osc_en == (i_timer2_sync || i_display_sync); endproperty
  a_psync: assert property (p_psync) else $error("psave main");
  property p_stby; asleep && o_sleep_mode == 3'h6 |->
    o_main_osc_en && gates == 5'h00; endproperty
  a_stby: assert property (p_stby) else $error("standby clocks");
  property p_adc; take && sel < 3'h2 && i_adc_enabled |=> ##[0:1] o_adc_start;
  endproperty
  a_adc: assert property (p_adc) else $error("no conversion");
  property p_rst; o_sleeping && i_reset_req |=> ##[0:2] o_restart_vector;
  endproperty
  a_rst: assert property (p_rst) else $error("no restart");
endmodule
bind smc_sleep_ctrl smc_sleep_asserts chk (.*);

// *** test/smc_wake_model.sv ***
// Wake-source model: a level request that the far side holds for a while.
`timescale 1ns/1ps
module smc_wake_model (
  input wire logic i_sys_clk,
  input wire logic i_fire,
  input wire logic [3:0] i_hold,
  output logic o_level
);
  logic [3:0] left = 4'h0;
  // The level outlasts the request so that a slow detector still sees it.
  always_ff @(posedge i_sys_clk) begin
    if (i_fire) begin
      left <= i_hold;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
  assign o_level = i_fire || left != 4'h0;
endmodule

// *** test/test_sleep_mode_controller.sv ***
// Self-checking bench for the sleep-mode controller.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t mismatch", $time); end end
module test_sleep_mode_controller;
  typedef struct packed {
    logic [2:0] sel;
    logic en;
    logic xtal;
    logic sleep;
    logic [4:0] gates;
    logic [3:0] wake;
  } smc_row_type;
  logic i_sys_clk = 1'h0, i_rstn = 1'h0, i_sleep_instr = 1'h0;
  logic i_sleep_enable_bit = 1'h0, i_crystal_selected = 1'h1;
  logic [2:0] i_sleep_state_select = 3'h0;
  logic [15:0] i_clock_source_fuses_wait = 16'h0003;
  logic i_reset_req = 1'h0, i_global_irq_en = 1'h0, i_adc_enabled = 1'h1;
  logic i_adc_done_irq = 1'h0, i_spm_ee_ready_irq = 1'h0;
  logic i_ext_zero_level_irq = 1'h0, i_ext_zero_edge_irq = 1'h0;
  logic i_serial_start_irq = 1'h0, i_display_irq = 1'h0;
  logic i_display_async = 1'h0, i_display_sync = 1'h0, i_timer2_ovf = 1'h0;
  logic i_timer2_cmp = 1'h0, i_timer2_async = 1'h0, i_timer2_sync = 1'h0;
  logic [1:0] i_timer2_irq_mask = 2'h0;
  logic i_other_io_irq = 1'h0, i_pin_change_irq, fire = 1'h0, seen;
  logic o_cpu_clk_en, o_flash_clk_en, o_io_clk_en, o_adc_clk_en;
  logic o_async_clk_en, o_t2_lcd_sync_clk_en, o_main_osc_en, o_timer_osc_en;
  logic o_adc_start, o_core_halt, o_restart_vector, o_sleeping;
  logic [2:0] o_sleep_mode;
  logic [4:0] gates;
  int failures = 0, n_tests = 0, n;
  // Wake count is START plus four HALT cycles plus the first active sample.
  smc_row_type rows [10] = '{
    '{3'h0, 1'h1, 1'h1, 1'h1, 5'h07, 4'h6},
    '{3'h1, 1'h1, 1'h1, 1'h1, 5'h03, 4'h6},
    '{3'h2, 1'h1, 1'h1, 1'h1, 5'h00, 4'h8},
    '{3'h3, 1'h1, 1'h1, 1'h1, 5'h00, 4'h8},
    '{3'h4, 1'h1, 1'h1, 1'h0, 5'h1F, 4'h0},
    '{3'h5, 1'h1, 1'h1, 1'h0, 5'h1F, 4'h0},
    '{3'h6, 1'h1, 1'h1, 1'h1, 5'h00, 4'hB},
    '{3'h7, 1'h1, 1'h1, 1'h0, 5'h1F, 4'h0},
    '{3'h6, 1'h1, 1'h0, 1'h0, 5'h1F, 4'h0},
    '{3'h0, 1'h0, 1'h1, 1'h0, 5'h1F, 4'h0}};
  assign gates = {o_cpu_clk_en, o_flash_clk_en, o_io_clk_en, o_adc_clk_en,
    o_async_clk_en};
  smc_sleep_ctrl dut (.*);
  smc_wake_model wake (.i_sys_clk(i_sys_clk), .i_fire(fire), .i_hold(4'h3),
    .o_level(i_pin_change_irq));
  always #2 i_sys_clk = ~i_sys_clk;
  task automatic step(int k = 1);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic print_verdict();
    if (failures == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_awake(output int cnt);
    cnt = 0;
    while (o_core_halt !== 1'h0) begin
      step();
      fire = 1'h0;
      cnt++;
      if (cnt > 40) begin
        failures++;
        print_verdict();
      end
    end
  endtask
  task automatic sleep_in(logic [2:0] s, logic e, logic x);
    i_sleep_state_select = s;
    i_sleep_enable_bit = e;
    i_crystal_selected = x;
    i_sleep_instr = 1'h1;
    step();
    i_sleep_instr = 1'h0;
    i_sleep_enable_bit = 1'h0;
    step(2);
  endtask
  initial begin
    step(5);
    i_rstn = 1'h1;
    step();
    `CHK({o_core_halt, gates}, 6'h1F)
    foreach (rows[i]) begin
      sleep_in(rows[i].sel, rows[i].en, rows[i].xtal);
      `CHK(o_sleeping, rows[i].sleep)
      `CHK(gates, rows[i].gates)
      if (rows[i].sleep) begin
        fire = 1'h1;
        wait_awake(n);
        `CHK(n, int'(rows[i].wake))
      end
    end
    sleep_in(3'h2, 1'h1, 1'h1);
    i_ext_zero_edge_irq = 1'h1;
    step(3);
    `CHK(o_sleeping, 1'h1)
    i_ext_zero_edge_irq = 1'h0;
    i_serial_start_irq = 1'h1;
    wait_awake(n);
    i_serial_start_irq = 1'h0;
    `CHK(n, 8)
    i_timer2_async = 1'h1;
    i_display_sync = 1'h1;
    i_global_irq_en = 1'h1;
    sleep_in(3'h3, 1'h1, 1'h1);
    i_timer2_ovf = 1'h1;
    i_timer2_cmp = 1'h1;
    step(3);
    `CHK(o_sleeping, 1'h1)
    `CHK(o_t2_lcd_sync_clk_en, 1'h1)
    i_timer2_irq_mask = 2'h1;
    wait_awake(n);
    i_timer2_ovf = 1'h0;
    i_timer2_cmp = 1'h0;
    `CHK(n, 8)
    sleep_in(3'h1, 1'h1, 1'h1);
    i_other_io_irq = 1'h1;
    step(3);
    `CHK(o_sleeping, 1'h1)
    `CHK(o_t2_lcd_sync_clk_en, 1'h0)
    i_ext_zero_level_irq = 1'h1;
    wait_awake(n);
    i_other_io_irq = 1'h0;
    i_ext_zero_level_irq = 1'h0;
    `CHK(n, 6)
    sleep_in(3'h6, 1'h1, 1'h1);
    i_reset_req = 1'h1;
    seen = 1'h0;
    repeat (3) begin
      step();
      seen = seen | o_restart_vector;
    end
    i_reset_req = 1'h0;
    `CHK(seen, 1'h1)
    wait_awake(n);
    print_verdict();
  end
endmodule
